// File: rtl/tpwf_ctrl.sv
// Partitioned transmit write buffer controller with polling arbiter.
// Assumes write pins are asynchronous and a write clock well below sys_clk_in.
//
// Overview of operation
// - While link disable is high the arbiter stops polling and every mapped port waits.
// - While the buffer is disabled the link carries idle instead of buffer data.
// - Writes into a disabled buffer are still taken and fill status stays correct.
// - Each write interface runs on its own write reference clock, free of sys_clk_in.
// - The full flag reports the partition picked by the three-bit select.
// - The full flag is high once the partition occupancy reaches the fill threshold.
// - The buffer divides into up to eight virtual partitions chosen by the select.
// - In 64-bit mode each partition is twice as deep as in 32-bit mode.
// - Several logical ports may map onto one partition.
// - A packet end moves the write pointer to the next line of the partition.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "tpwf_defines.svh"

module tpwf_ctrl #(
  parameter int DEPTH32 = 8,
  parameter int NUM_PORTS = 8
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic tx_write_ref_clk_in,
  input wire logic buffer_link_disable_in,
  input wire logic line_write_strobe_in,
  input wire logic packet_end_flag_in,
  input wire logic packet_error_in,
  input wire logic [2:0] virtual_fifo_select_in,
  input wire logic [7:0] byte_enable_in,
  input wire logic [63:0] tx_write_data_in,
  output logic partition_full_flag_out,
  output logic [63:0] link_data_out,
  output logic [7:0] link_be_out,
  output logic [$clog2(NUM_PORTS)-1:0] link_port_out,
  output logic link_eop_out,
  output logic link_err_out,
  output logic link_valid_out,
  output logic link_idle_out,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Sizes; DEPTH32 must be a power of two so a partition is an address slice
  localparam int NUM_PARTS = 8;
  localparam int SEL_W = 3;
  localparam int PART_MAX = 2 * DEPTH32;
  localparam int PTR_W = $clog2(PART_MAX);
  localparam int OCC_W = $clog2(PART_MAX + 1);
  localparam int PORT_W = $clog2(NUM_PORTS);
  localparam int AW = SEL_W + PTR_W;
  localparam int MEM_WORDS = NUM_PARTS * PART_MAX;
  ////////////////////////////////////////////////////////////////////////////
  // Pin capture
  tpwf_pkg::tpwf_wr_bundle_type pin_raw;
  tpwf_pkg::tpwf_wr_bundle_type wr_s;
  // All write pins pass one synchroniser instance, each bit through its own filter chain, so their delays match
  assign pin_raw = '{clk: tx_write_ref_clk_in, link_dis: buffer_link_disable_in,
    we: line_write_strobe_in, eop: packet_end_flag_in, err: packet_error_in,
    sel: virtual_fifo_select_in, be: byte_enable_in, data: tx_write_data_in};
  tpwf_sync #(
    .WIDTH($bits(tpwf_pkg::tpwf_wr_bundle_type))
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .async_in(pin_raw),
    .stable_out(wr_s)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [`TPWF_CTRL_W-1:0] ctrl_reg;
  logic [OCC_W-1:0] fill_reg;
  logic [SEL_W-1:0] map_reg [NUM_PORTS];
  logic [`TPWF_IRQ_W-1:0] irq_stat_reg;
  logic [`TPWF_IRQ_W-1:0] irq_mask_reg;
  logic [`TPWF_IRQ_W-1:0] irq_stat_next;
  logic [`TPWF_IRQ_W-1:0] irq_event;
  logic wr_clk_d_reg;
  logic link_dis_d_reg;
  logic full_reg;
  logic [PORT_W-1:0] rr_reg;
  wire mode64 = ctrl_reg[`TPWF_CTRL_MODE64_BIT];
  wire arb_en = ctrl_reg[`TPWF_CTRL_ARB_EN_BIT];
  ////////////////////////////////////////////////////////////////////////////
  // Partition geometry
  // Mode change is only safe with the buffer empty; pointers are not rebased
  wire [OCC_W-1:0] depth_now = mode64 ? OCC_W'(PART_MAX) : OCC_W'(DEPTH32);
  wire [PTR_W-1:0] ptr_mask = mode64 ? {PTR_W{1'b1}} : PTR_W'(DEPTH32 - 1);
  ////////////////////////////////////////////////////////////////////////////
  // Write side, one event per falling edge of the filtered write clock
  logic [PTR_W-1:0] wr_ptr_w [NUM_PARTS];
  logic [PTR_W-1:0] rd_ptr_w [NUM_PARTS];
  logic [OCC_W-1:0] occ_w [NUM_PARTS];
  // Falling edge sits half a write period after the writer launched its data
  wire wr_evt = wr_clk_d_reg & ~wr_s.clk;
  wire [PTR_W-1:0] wr_ptr_sel = wr_ptr_w[wr_s.sel];
  wire [OCC_W-1:0] occ_sel = occ_w[wr_s.sel];
  // Words with no byte enabled are dropped without a write
  wire wr_take = wr_evt & wr_s.we & (|wr_s.be);
  // Packet end in the first half of a line skips the second half
  wire wr_skip = wr_s.eop & ~wr_ptr_sel[0];
  wire [1:0] wr_adv = wr_skip ? 2'h2 : 2'h1;
  wire [OCC_W:0] wr_need = {1'b0, occ_sel} + {{(OCC_W - 1){1'b0}}, wr_adv};
  wire wr_room = wr_need <= {1'b0, depth_now};
  // Disable does not stop writes, only room does
  wire wr_do = wr_take & wr_room;
  wire wr_ovf = wr_take & ~wr_room;
  wire [AW-1:0] wr_addr = {wr_s.sel, wr_ptr_sel};
  wire [PTR_W-1:0] wr_pad_ptr = (wr_ptr_sel + PTR_W'(1)) & ptr_mask;
  wire [AW-1:0] wr_pad_addr = {wr_s.sel, wr_pad_ptr};

  tpwf_pkg::tpwf_word_type wr_word;
  tpwf_pkg::tpwf_word_type pad_word;
  assign wr_word = '{data: wr_s.data, be: wr_s.be, eop: wr_s.eop, err: wr_s.err, pad: 1'b0};
  assign pad_word = '{data: 64'h0, be: 8'h00, eop: 1'b0, err: 1'b0, pad: 1'b1};
  ////////////////////////////////////////////////////////////////////////////
  // Port polling arbiter
  wire [SEL_W-1:0] rd_part = map_reg[rr_reg];
  // Disable freezes the polling pointer so no mapped port is serviced
  wire arb_on = arb_en & ~wr_s.link_dis;
  wire rd_do = arb_on & (occ_w[rd_part] != {OCC_W{1'b0}});
  wire [AW-1:0] rd_addr = {rd_part, rd_ptr_w[rd_part]};
  ////////////////////////////////////////////////////////////////////////////
  // Buffer storage, no reset: contents only count below the occupancy
  tpwf_pkg::tpwf_word_type mem [MEM_WORDS];
  tpwf_pkg::tpwf_word_type rd_word;
  assign rd_word = mem[rd_addr];
  // Write port plus the pad mark of a skipped half line
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_do)
      mem[wr_addr] <= wr_word;
    if (wr_do && wr_skip)
      mem[wr_pad_addr] <= pad_word;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Per partition pointers and occupancy
  genvar p;
  generate
    for (p = 0; p < NUM_PARTS; p++)
    begin : g_part
      logic [PTR_W-1:0] wr_ptr_reg;
      logic [PTR_W-1:0] rd_ptr_reg;
      logic [OCC_W-1:0] occ_reg;
      logic [PTR_W-1:0] wr_ptr_next;
      logic [PTR_W-1:0] rd_ptr_next;
      logic [OCC_W-1:0] occ_next;
      wire wr_hit = wr_do & (wr_s.sel == SEL_W'(p));
      wire rd_hit = rd_do & (rd_part == SEL_W'(p));
      wire [OCC_W-1:0] occ_add = wr_hit ? OCC_W'(wr_adv) : {OCC_W{1'b0}};
      wire [OCC_W-1:0] occ_sub = rd_hit ? OCC_W'(1) : {OCC_W{1'b0}};
      // Wrap inside the active depth of the partition
      assign wr_ptr_next = wr_hit ? ((wr_ptr_reg + PTR_W'(wr_adv)) & ptr_mask) : wr_ptr_reg;
      assign rd_ptr_next = rd_hit ? ((rd_ptr_reg + PTR_W'(1)) & ptr_mask) : rd_ptr_reg;
      assign occ_next = occ_reg + occ_add - occ_sub;

      always_ff @(posedge sys_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          wr_ptr_reg <= {PTR_W{1'b0}};
          rd_ptr_reg <= {PTR_W{1'b0}};
          occ_reg <= {OCC_W{1'b0}};
        end
        else
        begin
          wr_ptr_reg <= wr_ptr_next;
          rd_ptr_reg <= rd_ptr_next;
          occ_reg <= occ_next;
        end
      end

      assign wr_ptr_w[p] = wr_ptr_reg;
      assign rd_ptr_w[p] = rd_ptr_reg;
      assign occ_w[p] = occ_reg;
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // Link output stage
  logic link_valid_reg;
  logic [63:0] link_data_reg;
  logic [7:0] link_be_reg;
  logic [PORT_W-1:0] link_port_reg;
  logic link_eop_reg;
  logic link_err_reg;
  // Pad slots are drained silently and show as idle
  wire link_valid_next = rd_do & ~rd_word.pad;
  // Data holds its last value while idle
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      link_valid_reg <= 1'b0;
      link_data_reg <= 64'h0;
      link_be_reg <= 8'h00;
      link_port_reg <= {PORT_W{1'b0}};
      link_eop_reg <= 1'b0;
      link_err_reg <= 1'b0;
    end
    else
    begin
      link_valid_reg <= link_valid_next;
      if (link_valid_next)
      begin
        link_data_reg <= rd_word.data;
        link_be_reg <= rd_word.be;
        link_port_reg <= rr_reg;
        link_eop_reg <= rd_word.eop;
        link_err_reg <= rd_word.err;
      end
    end
  end

  assign link_data_out = link_data_reg;
  assign link_be_out = link_be_reg;
  assign link_port_out = link_port_reg;
  assign link_eop_out = link_eop_reg;
  assign link_err_out = link_err_reg;
  assign link_valid_out = link_valid_reg;
  assign link_idle_out = ~link_valid_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Full flag, arbiter pointer and edge history
  // Settles within a few sys_clk cycles, long before the next write edge
  wire full_next = occ_w[wr_s.sel] >= fill_reg;
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      full_reg <= 1'b0;
      wr_clk_d_reg <= 1'b0;
      link_dis_d_reg <= 1'b0;
      rr_reg <= {PORT_W{1'b0}};
    end
    else
    begin
      full_reg <= full_next;
      wr_clk_d_reg <= wr_s.clk;
      link_dis_d_reg <= wr_s.link_dis;
      if (arb_on)
        rr_reg <= rr_reg + PORT_W'(1);
    end
  end

  assign partition_full_flag_out = full_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events; a new event beats a software clear in the same cycle
  assign irq_event[`TPWF_IRQ_FULL_BIT] = full_next & ~full_reg;
  assign irq_event[`TPWF_IRQ_OVF_BIT] = wr_ovf;
  assign irq_event[`TPWF_IRQ_DIS_BIT] = wr_s.link_dis & ~link_dis_d_reg;
  assign irq_out = |(irq_stat_reg & irq_mask_reg);
  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic ahb_wr_reg;
  logic [`TPWF_ADDR_W-1:0] ahb_addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] map_flat;
  logic [31:0] rd_mux;
  logic [NUM_PARTS-1:0] nonempty;
  wire ahb_sel = hsel_in & hready_in & htrans_in[`TPWF_HTRANS_ACTIVE_BIT];
  wire [`TPWF_ADDR_W-1:0] ahb_a = haddr_in[`TPWF_ADDR_W-1:0];
  wire wr_ctrl = ahb_wr_reg & (ahb_addr_reg == `TPWF_OFS_CTRL);
  wire wr_fill = ahb_wr_reg & (ahb_addr_reg == `TPWF_OFS_FILL);
  wire wr_map = ahb_wr_reg & (ahb_addr_reg == `TPWF_OFS_MAP);
  wire wr_istat = ahb_wr_reg & (ahb_addr_reg == `TPWF_OFS_IRQ_STAT);
  wire wr_imask = ahb_wr_reg & (ahb_addr_reg == `TPWF_OFS_IRQ_MASK);
  wire [`TPWF_IRQ_W-1:0] irq_clr = wr_istat ? hwdata_in[`TPWF_IRQ_W-1:0] : {`TPWF_IRQ_W{1'b0}};

  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_event;
  // Packed views of the map and partition fill state
  genvar m;
  generate
    for (m = 0; m < NUM_PARTS; m++)
    begin : g_ne
      assign nonempty[m] = occ_w[m] != {OCC_W{1'b0}};
    end
    for (m = 0; m < 32 / `TPWF_MAP_FIELD_W; m++)
    begin : g_map
      if (m < NUM_PORTS)
      begin : g_used
        assign map_flat[m*`TPWF_MAP_FIELD_W +: `TPWF_MAP_FIELD_W] = map_reg[m];
      end
      else
      begin : g_free
        assign map_flat[m*`TPWF_MAP_FIELD_W +: `TPWF_MAP_FIELD_W] = 3'h0;
      end
    end
    assign map_flat[31:30] = 2'h0;
  endgenerate

  // Read selection; unmapped offsets read zero
  assign rd_mux =
    (ahb_a == `TPWF_OFS_CTRL) ? {{(32 - `TPWF_CTRL_W){1'b0}}, ctrl_reg} :
    (ahb_a == `TPWF_OFS_FILL) ? {{(32 - OCC_W){1'b0}}, fill_reg} :
    (ahb_a == `TPWF_OFS_MAP) ? map_flat :
    (ahb_a == `TPWF_OFS_STATUS) ?
      ({{(32 - OCC_W){1'b0}}, occ_w[wr_s.sel]} << `TPWF_STAT_OCC_LSB) |
      ({{(32 - NUM_PARTS){1'b0}}, nonempty} << `TPWF_STAT_NE_LSB) |
      {30'h0, full_reg, wr_s.link_dis} :
    (ahb_a == `TPWF_OFS_IRQ_STAT) ? {{(32 - `TPWF_IRQ_W){1'b0}}, irq_stat_reg} :
    (ahb_a == `TPWF_OFS_IRQ_MASK) ? {{(32 - `TPWF_IRQ_W){1'b0}}, irq_mask_reg} :
    32'h0000_0000;

  // Address phase capture and read data launch
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ahb_wr_reg <= 1'b0;
      ahb_addr_reg <= {`TPWF_ADDR_W{1'b0}};
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ahb_wr_reg <= ahb_sel & hwrite_in;
      if (ahb_sel)
        ahb_addr_reg <= ahb_a;
      if (ahb_sel && !hwrite_in)
        hrdata_reg <= rd_mux;
    end
  end

  // Register writes land at the end of the data phase
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl_reg <= `TPWF_CTRL_RST;
      fill_reg <= OCC_W'(`TPWF_FILL_RST);
      irq_stat_reg <= {`TPWF_IRQ_W{1'b0}};
      irq_mask_reg <= `TPWF_IRQ_MASK_RST;
      for (int i = 0; i < NUM_PORTS; i++)
        map_reg[i] <= SEL_W'(i % NUM_PARTS);
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      if (wr_ctrl)
        ctrl_reg <= hwdata_in[`TPWF_CTRL_W-1:0];
      if (wr_fill)
        fill_reg <= hwdata_in[OCC_W-1:0];
      if (wr_imask)
        irq_mask_reg <= hwdata_in[`TPWF_IRQ_W-1:0];
      if (wr_map)
        for (int i = 0; i < NUM_PORTS; i++)
          map_reg[i] <= hwdata_in[i*`TPWF_MAP_FIELD_W +: `TPWF_MAP_FIELD_W];
    end
  end

  assign hrdata_out = hrdata_reg;
  assign hreadyout_out = 1'b1;
  assign hresp_out = `TPWF_HRESP_OKAY;

endmodule

// File: rtl/tpwf_defines.svh
// Register offsets, field positions, reset values and bus codes of the
// partitioned transmit write buffer controller.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TPWF_DEFINES_SVH
`define TPWF_DEFINES_SVH

// Register byte offsets, decoded on the low address byte
`define TPWF_ADDR_W 8
`define TPWF_OFS_CTRL 8'h00
`define TPWF_OFS_FILL 8'h04
`define TPWF_OFS_MAP 8'h08
`define TPWF_OFS_STATUS 8'h0C
`define TPWF_OFS_IRQ_STAT 8'h10
`define TPWF_OFS_IRQ_MASK 8'h14

// Control register fields
`define TPWF_CTRL_MODE64_BIT 0
`define TPWF_CTRL_ARB_EN_BIT 1
`define TPWF_CTRL_W 2
`define TPWF_CTRL_RST 2'h2

// Fill level threshold reset value
`define TPWF_FILL_RST 32'h0000_0006

// Port to partition map: one field per port
`define TPWF_MAP_FIELD_W 3

// Status register fields
`define TPWF_STAT_DIS_BIT 0
`define TPWF_STAT_FULL_BIT 1
`define TPWF_STAT_NE_LSB 8
`define TPWF_STAT_OCC_LSB 16

// Interrupt bits, shared by status and mask
`define TPWF_IRQ_W 3
`define TPWF_IRQ_FULL_BIT 0
`define TPWF_IRQ_OVF_BIT 1
`define TPWF_IRQ_DIS_BIT 2
`define TPWF_IRQ_MASK_RST 3'h0

// Bus codes
`define TPWF_HTRANS_ACTIVE_BIT 1
`define TPWF_HRESP_OKAY 1'h0

`endif

// File: rtl/tpwf_pkg.sv
// Types shared by the partitioned transmit write buffer controller.
// Assumes the defines header sits beside it in rtl/.
`include "tpwf_defines.svh"

package tpwf_pkg;

  // Write side pins, carried together through the pin synchroniser
  typedef struct packed {
    logic clk;
    logic link_dis;
    logic we;
    logic eop;
    logic err;
    logic [2:0] sel;
    logic [7:0] be;
    logic [63:0] data;
  } tpwf_wr_bundle_type;

  // One stored buffer word; pad marks the unused half of a line after a packet end
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] be;
    logic eop;
    logic err;
    logic pad;
  } tpwf_word_type;

endpackage

// File: rtl/tpwf_sync.sv
// Three stage pin synchroniser with a per-bit agreement filter.
// Assumes its inputs are asynchronous to sys_clk_in; output is a clean level.
`timescale 1ns/100ps

module tpwf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);

  ////////////////////////////////////////////////////////////////////////////
  // One chain per bit; the first stage feeds only the second
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic filt_reg;
      // A change is taken only once stages two and three agree
      always_ff @(posedge sys_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          filt_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= async_in[b];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            filt_reg <= s3_reg;
        end
      end
      assign stable_out[b] = filt_reg;
    end
  endgenerate

endmodule

// File: tb/tpwf_ctrl_props.sv
// Concurrent checks on the top ports of the partitioned write buffer controller.
// Assumes the defines header is on the include path; bound onto tpwf_ctrl below.
`timescale 1ns/100ps
`include "tpwf_defines.svh"
////////////////////////////////////////////////////////////////
module tpwf_ctrl_props (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic buffer_link_disable_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic irq_out,
  input wire logic partition_full_flag_out,
  input wire logic [63:0] link_data_out,
  input wire logic link_eop_out,
  input wire logic link_err_out,
  input wire logic link_valid_out,
  input wire logic link_idle_out
);
  logic [3:0] dis_cnt_reg;
  // Bus transfer decode
  wire logic take = hsel_in && hready_in && htrans_in[1];
  wire logic rd_take = take && !hwrite_in;
  wire logic wr_take = take && hwrite_in;
  wire logic [7:0] ofs = haddr_in[7:0];

  // Cycles the disable pin has stood high; the pin filter lags, so allow 8
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      dis_cnt_reg <= 4'h0;
    else if (!buffer_link_disable_in)
      dis_cnt_reg <= 4'h0;
    else if (dis_cnt_reg != 4'hF)
      dis_cnt_reg <= dis_cnt_reg + 4'h1;
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////////////////////////////
  // Link side
  a_idle_mirror: assert property (link_idle_out == !link_valid_out)
    else $error("idle flag is not the inverse of valid");
  a_dis_quiet: assert property (dis_cnt_reg >= 4'h8 |-> !link_valid_out)
    else $error("word sent while the buffer is disabled");
  a_word_hold: assert property (!link_valid_out |-> $stable(link_data_out))
    else $error("link data moved without a word");
  a_err_eop: assert property (link_valid_out && link_err_out |-> link_eop_out)
    else $error("error flag sent without packet end");
  a_reset_quiet: assert property ($rose(arst_n_in) |-> !irq_out && !link_valid_out
    && !partition_full_flag_out)
    else $error("outputs active after reset");
  // Register side
  a_bus_okay: assert property (hreadyout_out && hresp_out == `TPWF_HRESP_OKAY)
    else $error("bus answer not ready and okay");
  a_rd_hold: assert property (!rd_take |=> $stable(hrdata_out))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_take && ofs > 8'h17 |=> hrdata_out == 32'h0)
    else $error("unmapped offset read nonzero");
  a_mask_blocks: assert property (wr_take && ofs == 8'h14 ##1 hwdata_in == 32'h0
    |=> !irq_out)
    else $error("interrupt high with all sources masked");
  a_status_dis: assert property (rd_take && ofs == 8'h0C && dis_cnt_reg >= 4'h8
    |=> hrdata_out[0])
    else $error("status misses the link disable");
  c_back_to_back: cover property (link_valid_out ##1 link_valid_out);
  c_irq_rise: cover property ($rose(irq_out));
  c_full_rise: cover property ($rose(partition_full_flag_out));
endmodule

bind tpwf_ctrl tpwf_ctrl_props tpwf_ctrl_props_inst (
  .sys_clk_in, .arst_n_in, .buffer_link_disable_in, .hsel_in, .haddr_in, .htrans_in,
  .hwrite_in, .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .hrdata_out, .irq_out,
  .partition_full_flag_out, .link_data_out, .link_eop_out, .link_err_out,
  .link_valid_out, .link_idle_out
);

// File: tb/tpwf_writer_model.sv
// Behavioural user logic that writes words into the transmit buffer pins.
// Assumes sys_clk_in only paces its own write clock, which is unrelated otherwise.
`timescale 1ns/100ps
module tpwf_writer_model (
  input wire logic sys_clk_in,
  output logic wclk_out,
  output logic strobe_out,
  output logic eop_out,
  output logic err_out,
  output logic [2:0] sel_out,
  output logic [7:0] be_out,
  output logic [63:0] data_out
);
  // Write clock stands low between words
  initial
  begin
    wclk_out = 1'b0;
    strobe_out = 1'b0;
    eop_out = 1'b0;
    err_out = 1'b0;
    sel_out = 3'h0;
    be_out = 8'h00;
    data_out = 64'h0;
  end
  ////////////////////////////////////////////////////////////////
  // Partition select is a level held between words
  task automatic set_sel(input logic [2:0] s);
    @(posedge sys_clk_in);
    sel_out <= s;
  endtask
  // One word per write clock period of 13 cycles, launched on its rising edge
  task automatic send(input logic eop, input logic [63:0] d);
    @(posedge sys_clk_in);
    wclk_out <= 1'b1;
    strobe_out <= 1'b1;
    eop_out <= eop;
    err_out <= eop;
    be_out <= 8'hFF;
    data_out <= d;
    repeat (6) @(posedge sys_clk_in);
    wclk_out <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    // Released data lines show the inverse and the controls drop, so stale data never looks valid
    strobe_out <= 1'b0;
    eop_out <= 1'b0;
    err_out <= 1'b0;
    be_out <= 8'h00;
    data_out <= ~d;
  endtask
endmodule

// File: tb/test_tx_partitioned_write_fifo_ctrl.sv
// Register and pin level tests of the partitioned write buffer controller.
// Assumes the checker is bound by its own file and the writer model drives the pins.
`timescale 1ns/100ps
module test_tx_partitioned_write_fifo_ctrl;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic link_dis = 1'b0;
  logic wclk, strobe, eop, err, full, l_eop, l_err, l_valid, l_idle;
  logic [2:0] sel, l_port;
  logic [7:0] be, l_be;
  logic [63:0] wdata, l_data;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, irq;
  logic [31:0] hrdata, q, map_v;
  logic [63:0] sent_q[$];
  logic [2:0] port_q[$];
  int fails = 0;
  int checks = 0;
  int n5;

  always #12.5 sys_clk = ~sys_clk;

  tpwf_ctrl #(.DEPTH32(8), .NUM_PORTS(8)) tpwf_ctrl_inst (
    .sys_clk_in(sys_clk), .arst_n_in(arst_n), .tx_write_ref_clk_in(wclk),
    .buffer_link_disable_in(link_dis), .line_write_strobe_in(strobe),
    .packet_end_flag_in(eop), .packet_error_in(err), .virtual_fifo_select_in(sel),
    .byte_enable_in(be), .tx_write_data_in(wdata), .partition_full_flag_out(full),
    .link_data_out(l_data), .link_be_out(l_be), .link_port_out(l_port),
    .link_eop_out(l_eop), .link_err_out(l_err), .link_valid_out(l_valid),
    .link_idle_out(l_idle), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .irq_out(irq));

  tpwf_writer_model tpwf_writer_model_inst (
    .sys_clk_in(sys_clk), .wclk_out(wclk), .strobe_out(strobe), .eop_out(eop),
    .err_out(err), .sel_out(sel), .be_out(be), .data_out(wdata));

  // Record every word handed to the link
  always @(posedge sys_clk)
  begin
    if (l_valid === 1'b1)
    begin
      sent_q.push_back(l_data);
      port_q.push_back(l_port);
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // One single AHB transfer; read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(64'(q), 64'(exp));
  endtask
  // A word from the writer, then settle before looking at outputs
  task automatic put(input logic e, input logic [63:0] d);
    tpwf_writer_model_inst.send(e, d);
    @(negedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog: the whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    // Reset values and an unmapped offset
    map_v = 32'h0;
    for (int i = 0; i < 8; i++)
      map_v[3*i +: 3] = 3'(i);
    rd(8'h00, 32'h2);
    rd(8'h04, 32'h6);
    rd(8'h08, map_v);
    rd(8'h14, 32'h0);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, 32'h0);
    // Disabled buffer keeps taking words and reports its fill
    link_dis <= 1'b1;
    wr(8'h04, 32'h4);
    tpwf_writer_model_inst.set_sel(3'h3);
    for (int i = 0; i < 4; i++)
    begin
      put(1'b0, 64'(i));
      check(64'(full), 64'(i == 3));
    end
    rd(8'h0C, 32'h0004_0803);
    tpwf_writer_model_inst.set_sel(3'h2);
    repeat (8) @(posedge sys_clk);
    check(64'(full), 64'h0);
    rd(8'h0C, 32'h0000_0801);
    tpwf_writer_model_inst.set_sel(3'h3);
    for (int i = 4; i < 8; i++)
      put(1'b0, 64'(i));
    rd(8'h10, 32'h5);
    put(1'b0, 64'h99);
    rd(8'h10, 32'h7);
    check(64'(sent_q.size()), 64'h0);
    // Overflow interrupt: unmask, see it, clear it
    wr(8'h14, 32'h2);
    @(negedge sys_clk);
    check(64'(irq), 64'h1);
    wr(8'h10, 32'h2);
    @(negedge sys_clk);
    check(64'(irq), 64'h0);
    rd(8'h10, 32'h5);
    wr(8'h14, 32'h5);
    @(negedge sys_clk);
    check(64'(irq), 64'h1);
    wr(8'h14, 32'h0);
    @(negedge sys_clk);
    check(64'(irq), 64'h0);
    // Enable: nothing leaves with the arbiter off, then the held words go in order
    wr(8'h00, 32'h0);
    @(posedge sys_clk);
    link_dis <= 1'b0;
    repeat (40) @(posedge sys_clk);
    check(64'(sent_q.size()), 64'h0);
    wr(8'h00, 32'h2);
    repeat (120) @(posedge sys_clk);
    check(64'(sent_q.size()), 64'h8);
    for (int i = 0; i < 8; i++)
    begin
      check(sent_q[i], 64'(i));
      check(64'(port_q[i]), 64'h3);
    end
    check(64'(full), 64'h0);
    check(64'({l_eop, l_err, l_be}), 64'h0FF);
    // 64-bit mode, port 5 shares partition 3, packet end pads the line
    link_dis <= 1'b1;
    wr(8'h00, 32'h3);
    wr(8'h08, (map_v & ~32'h0003_8000) | 32'h0001_8000);
    wr(8'h04, 32'h10);
    wr(8'h10, 32'h7);
    put(1'b1, 64'h100);
    rd(8'h0C, 32'h0002_0801);
    for (int i = 0; i < 14; i++)
      put(1'b0, 64'(i + 'h101));
    rd(8'h0C, 32'h0010_0803);
    rd(8'h10, 32'h1);
    put(1'b0, 64'h1FF);
    rd(8'h10, 32'h3);
    @(posedge sys_clk);
    link_dis <= 1'b0;
    repeat (150) @(posedge sys_clk);
    check(64'(sent_q.size()), 64'd23);
    n5 = 0;
    for (int i = 8; i < sent_q.size(); i++)
      n5 += (port_q[i] === 3'h5);
    check(64'(n5 > 0 && n5 < 15), 64'h1);
    give_verdict();
  end
endmodule
